/* design/npic_defs.vh */
`ifndef NPIC_DEFS_VH
`define NPIC_DEFS_VH
// Register byte addresses on the APB bus.
`define NPIC_ADDR_CC 12'h000
`define NPIC_ADDR_PRIO0 12'h004
`define NPIC_ADDR_PRIO1 12'h008
`define NPIC_ADDR_PRIO2 12'h00C
`define NPIC_ADDR_PRIO3 12'h010
`define NPIC_ADDR_CMD 12'h014
`define NPIC_ADDR_STAT 12'h018
`define NPIC_ADDR_ENA 12'h01C
`define NPIC_ADDR_EDGE 12'h020
`define NPIC_ADDR_HALTOK 12'h024
`define NPIC_ADDR_CLR 12'h028
// Condition code fields.
`define NPIC_CC_HI 5
`define NPIC_CC_LO 3
`define NPIC_CC_RESET 8'hEA
`define NPIC_PRIO_RESET 8'hFF
// Priority encodings, hi then lo.
`define NPIC_LVL0 2'h2
`define NPIC_LVL1 2'h1
`define NPIC_LVL2 2'h0
`define NPIC_LVL3 2'h3
// Vector table.
`define NPIC_VEC_RESET 16'hFFFE
`define NPIC_VEC_TRAP 16'hFFFC
`define NPIC_VEC_TOP 16'hFFFA
// Command register bits.
`define NPIC_CMD_ENABLE 0
`define NPIC_CMD_DISABLE 1
`define NPIC_CMD_HALT 2
`define NPIC_CMD_WAIT 3
`define NPIC_CMD_TRAP 4
`define NPIC_CMD_RETURN 5
`define NPIC_CMD_INSTR_DONE 6
`endif

/* design/npic_arbiter.v */
`timescale 1ns/1ps
module npic_arbiter #(
  parameter NSRC = 14
)
(
  // Requests and priorities.
  input wire [NSRC-1:0] reqValid,
  input wire [2*NSRC-1:0] reqPrio,
  input wire [1:0] curPrio,
  // Winner.
  output reg winValid,
  output reg [3:0] winIdx,
  output reg [1:0] winPrio
);
  // Maps the two-bit encoding onto a rank where larger means more urgent.
  function [1:0] rank;
    input [1:0] enc;
    begin
      case (enc)
        2'h2: rank = 2'h0;
        2'h1: rank = 2'h1;
        2'h0: rank = 2'h2;
        default: rank = 2'h3;
      endcase
    end
  endfunction

  integer i;
  reg [1:0] bestRank;
  reg [1:0] p;

  // Lower index is higher hardware priority, so scanning downward lets it win ties.
  always @*
  begin
    winValid = 1'b0;
    winIdx = 4'h0;
    winPrio = 2'h0;
    bestRank = 2'h0;
    p = 2'h0;
    for (i = NSRC - 1; i >= 0; i = i - 1)
    begin
      p = reqPrio[2*i +: 2];
      if (reqValid[i] && (rank(p) > rank(curPrio)) && (!winValid || rank(p) >= bestRank))
      begin
        winValid = 1'b1;
        winIdx = i[3:0];
        winPrio = p;
        bestRank = rank(p);
      end
    end
  end
endmodule // npic_arbiter

/* design/npic_nested_irq.v */
`timescale 1ns/1ps
`include "npic_defs.vh"
module npic_nested_irq #(
  parameter NSRC = 14,
  parameter NEXT = 4,
  parameter PINS = 4
)
(
  // Clock and reset.
  input wire clk_sys,
  input wire reset_n,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // External pins, NEXT lines of PINS pins each.
  input wire [NEXT*PINS-1:0] extPins,
  input wire [NEXT*PINS-1:0] extPinSel,
  // Peripheral event flags for sources NEXT and above.
  input wire [NSRC-1:0] periphFlag,
  // CPU handshake.
  output reg entryStart,
  output reg entryStack,
  output reg [15:0] vectorAddr,
  output reg cpuAwake
);
  localparam ST_RUN = 2'h0;
  localparam ST_HALT = 2'h1;
  localparam ST_WAIT = 2'h2;

  reg [7:0] ccReg_r;
  reg [7:0] prioReg_r [0:3];
  reg [NSRC-1:0] enable_r;
  reg [NSRC-1:0] edgeMode_r;
  reg [NSRC-1:0] haltOk_r;
  reg [NSRC-1:0] latch_r;
  reg [NEXT-1:0] extLevelD_r;
  reg [NSRC-1:0] flagSync1_r;
  reg [NSRC-1:0] flagSync2_r;
  reg [NEXT*PINS-1:0] pinSync1_r;
  reg [NEXT*PINS-1:0] pinSync2_r;
  reg [1:0] mode_r;
  reg trapPend_r;
  reg resetPend_r;
  reg [1:0] resumePrio_r;
  reg haltExit_r;

  wire apbAccess = psel && penable;
  wire apbWrite = apbAccess && pwrite;
  wire [1:0] curPrio = {ccReg_r[`NPIC_CC_HI], ccReg_r[`NPIC_CC_LO]};
  wire cmdWr = apbWrite && (paddr == `NPIC_ADDR_CMD);
  wire clrWr = apbWrite && (paddr == `NPIC_ADDR_CLR);

  // Combine the selected pins of each external line.
  reg [NEXT-1:0] extLevel;
  integer k;
  always @*
  begin
    for (k = 0; k < NEXT; k = k + 1)
      extLevel[k] = |(pinSync2_r[k*PINS +: PINS] & extPinSel[k*PINS +: PINS]);
  end

  wire [NEXT-1:0] extRise = extLevel & ~extLevelD_r;

  // Raw requests: external lines first, then peripheral flags.
  reg [NSRC-1:0] rawReq;
  integer j;
  always @*
  begin
    for (j = 0; j < NSRC; j = j + 1)
    begin
      if (j < NEXT)
        rawReq[j] = edgeMode_r[j] ? extRise[j] : extLevel[j];
      else
        rawReq[j] = flagSync2_r[j];
    end
  end

  wire [NSRC-1:0] pending = latch_r & enable_r;
  // External lines can always leave halt; peripherals only where software allows it.
  wire [NSRC-1:0] extMask = {{(NSRC-NEXT){1'b0}}, {NEXT{1'b1}}};
  wire [NSRC-1:0] haltCapable = haltOk_r | extMask;
  wire [NSRC-1:0] haltPend = pending & haltCapable;

  // The first entry after halt serves only halt-capable sources; the others wait one pass.
  // If the waking request vanished before that entry, plain arbitration resumes.
  wire [NSRC-1:0] candidates = (haltExit_r && (|haltPend)) ? haltPend : pending;

  wire [2*NSRC-1:0] prioFlat;
  genvar g;
  generate
    for (g = 0; g < NSRC; g = g + 1)
    begin : gPrio
      assign prioFlat[2*g +: 2] = prioReg_r[g/4][2*(g%4) +: 2];
    end
  endgenerate

  wire winValid;
  wire [3:0] winIdx;
  wire [1:0] winPrio;

  npic_arbiter #(
    .NSRC(NSRC)
  ) uArb (
    .reqValid(candidates),
    .reqPrio(prioFlat),
    .curPrio(curPrio),
    .winValid(winValid),
    .winIdx(winIdx),
    .winPrio(winPrio)
  );

  // Priority write filter: a field written as level zero keeps its old value.
  function [7:0] prioMerge;
    input [7:0] oldVal;
    input [7:0] newVal;
    integer f;
    begin
      for (f = 0; f < 4; f = f + 1)
        prioMerge[2*f +: 2] = (newVal[2*f +: 2] == `NPIC_LVL0) ?
          oldVal[2*f +: 2] : newVal[2*f +: 2];
    end
  endfunction

  // Merged value for the last register, whose upper nibble is read-only ones.
  wire [7:0] prio3Merged = prioMerge(prioReg_r[3], pwdata[7:0]);

  function [7:0] ccWithPrio;
    input [7:0] cc;
    input [1:0] lvl;
    begin
      ccWithPrio = cc;
      ccWithPrio[`NPIC_CC_HI] = lvl[1];
      ccWithPrio[`NPIC_CC_LO] = lvl[0];
    end
  endfunction

  // Trap and interrupt entries are launched only at an instruction boundary reported by the CPU.
  wire instrDone = cmdWr && pwdata[`NPIC_CMD_INSTR_DONE];
  // A trap written together with instruction done is taken in that same access.
  wire trapCmd = cmdWr && pwdata[`NPIC_CMD_TRAP];
  wire anyWake = (|pending) || trapPend_r || trapCmd;
  wire haltWake = (|haltPend) || trapPend_r || trapCmd;
  wire takeTrap = (trapPend_r || trapCmd) && (mode_r == ST_RUN) && instrDone;
  wire takeIrq = !takeTrap && !resetPend_r && winValid && (mode_r == ST_RUN) && instrDone;

  // Status word: latches low, then mode, trap and reset pending flags.
  reg [31:0] statWord;
  always @*
  begin
    statWord = 32'h00000000;
    statWord[NSRC-1:0] = latch_r;
    statWord[17:16] = mode_r;
    statWord[18] = trapPend_r;
    statWord[19] = resetPend_r;
  end

  integer n;
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ccReg_r <= `NPIC_CC_RESET;
      for (n = 0; n < 4; n = n + 1)
        prioReg_r[n] <= `NPIC_PRIO_RESET;
      enable_r <= {NSRC{1'b0}};
      edgeMode_r <= {NSRC{1'b0}};
      haltOk_r <= {NSRC{1'b0}};
      latch_r <= {NSRC{1'b0}};
      extLevelD_r <= {NEXT{1'b0}};
      flagSync1_r <= {NSRC{1'b0}};
      flagSync2_r <= {NSRC{1'b0}};
      pinSync1_r <= {NEXT*PINS{1'b0}};
      pinSync2_r <= {NEXT*PINS{1'b0}};
      mode_r <= ST_RUN;
      trapPend_r <= 1'b0;
      resetPend_r <= 1'b1;
      resumePrio_r <= `NPIC_LVL3;
      haltExit_r <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      entryStart <= 1'b0;
      entryStack <= 1'b0;
      vectorAddr <= 16'h0000;
      cpuAwake <= 1'b1;
    end
    else
    begin
      pinSync1_r <= extPins;
      pinSync2_r <= pinSync1_r;
      flagSync1_r <= periphFlag;
      flagSync2_r <= flagSync1_r;
      extLevelD_r <= extLevel;
      entryStart <= 1'b0;
      entryStack <= 1'b0;
      // APB answers in the setup cycle's following edge, zero wait states after setup.
      pready <= psel && !penable;
      pslverr <= 1'b0;
      // Latch requests; a clear in the same cycle loses to a new event.
      latch_r <= (latch_r & ~(clrWr ? pwdata[NSRC-1:0] : {NSRC{1'b0}})) | rawReq;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          `NPIC_ADDR_CC: prdata <= {24'h000000, ccReg_r};
          `NPIC_ADDR_PRIO0: prdata <= {24'h000000, prioReg_r[0]};
          `NPIC_ADDR_PRIO1: prdata <= {24'h000000, prioReg_r[1]};
          `NPIC_ADDR_PRIO2: prdata <= {24'h000000, prioReg_r[2]};
          `NPIC_ADDR_PRIO3: prdata <= {24'h000000, prioReg_r[3]};
          `NPIC_ADDR_STAT: prdata <= statWord;
          `NPIC_ADDR_ENA: prdata <= {{(32-NSRC){1'b0}}, enable_r};
          `NPIC_ADDR_EDGE: prdata <= {{(32-NSRC){1'b0}}, edgeMode_r};
          `NPIC_ADDR_HALTOK: prdata <= {{(32-NSRC){1'b0}}, haltOk_r};
          `NPIC_ADDR_CMD: prdata <= 32'h00000000;
          `NPIC_ADDR_CLR: prdata <= 32'h00000000;
          default: prdata <= 32'h00000000;
        endcase
      end
      if (psel && !penable)
      begin
        case (paddr)
          `NPIC_ADDR_CC, `NPIC_ADDR_PRIO0, `NPIC_ADDR_PRIO1, `NPIC_ADDR_PRIO2,
          `NPIC_ADDR_PRIO3, `NPIC_ADDR_CMD, `NPIC_ADDR_STAT, `NPIC_ADDR_ENA,
          `NPIC_ADDR_EDGE, `NPIC_ADDR_HALTOK, `NPIC_ADDR_CLR: pslverr <= 1'b0;
          default: pslverr <= 1'b1;
        endcase
      end
      if (apbWrite && pready)
      begin
        case (paddr)
          `NPIC_ADDR_CC: ccReg_r <= pwdata[7:0];
          `NPIC_ADDR_PRIO0: prioReg_r[0] <= prioMerge(prioReg_r[0], pwdata[7:0]);
          `NPIC_ADDR_PRIO1: prioReg_r[1] <= prioMerge(prioReg_r[1], pwdata[7:0]);
          `NPIC_ADDR_PRIO2: prioReg_r[2] <= prioMerge(prioReg_r[2], pwdata[7:0]);
          `NPIC_ADDR_PRIO3: prioReg_r[3] <= {4'hF, prio3Merged[3:0]};
          `NPIC_ADDR_ENA: enable_r <= pwdata[NSRC-1:0];
          `NPIC_ADDR_EDGE: edgeMode_r <= pwdata[NSRC-1:0];
          `NPIC_ADDR_HALTOK: haltOk_r <= pwdata[NSRC-1:0];
          default: ;
        endcase
        if (paddr == `NPIC_ADDR_CMD)
        begin
          if (pwdata[`NPIC_CMD_ENABLE])
            ccReg_r <= ccWithPrio(ccReg_r, `NPIC_LVL0);
          if (pwdata[`NPIC_CMD_DISABLE])
            ccReg_r <= ccWithPrio(ccReg_r, `NPIC_LVL3);
          if (pwdata[`NPIC_CMD_HALT])
          begin
            ccReg_r <= ccWithPrio(ccReg_r, `NPIC_LVL0);
            mode_r <= ST_HALT;
            cpuAwake <= 1'b0;
          end
          if (pwdata[`NPIC_CMD_WAIT])
          begin
            ccReg_r <= ccWithPrio(ccReg_r, `NPIC_LVL0);
            mode_r <= ST_WAIT;
            cpuAwake <= 1'b0;
          end
          if (pwdata[`NPIC_CMD_TRAP])
            trapPend_r <= 1'b1;
          if (pwdata[`NPIC_CMD_RETURN])
            ccReg_r <= ccWithPrio(ccReg_r, resumePrio_r);
        end
      end
      // Low power exit.
      case (mode_r)
        ST_HALT:
          if (haltWake)
          begin
            mode_r <= ST_RUN;
            cpuAwake <= 1'b1;
            haltExit_r <= 1'b1;
          end
        ST_WAIT:
          if (anyWake)
          begin
            mode_r <= ST_RUN;
            cpuAwake <= 1'b1;
          end
        default: ;
      endcase
      // Reset vector first, with no stacking, at level three.
      if (resetPend_r)
      begin
        resetPend_r <= 1'b0;
        entryStart <= 1'b1;
        vectorAddr <= `NPIC_VEC_RESET;
      end
      else if (takeTrap)
      begin
        trapPend_r <= 1'b0;
        haltExit_r <= 1'b0;
        entryStart <= 1'b1;
        entryStack <= 1'b1;
        vectorAddr <= `NPIC_VEC_TRAP;
        resumePrio_r <= curPrio;
        ccReg_r <= ccWithPrio(ccReg_r, `NPIC_LVL3);
      end
      else if (takeIrq)
      begin
        haltExit_r <= 1'b0;
        entryStart <= 1'b1;
        entryStack <= 1'b1;
        // Vector pairs descend from the top by hardware priority.
        vectorAddr <= `NPIC_VEC_TOP - {11'h000, winIdx, 1'b0};
        resumePrio_r <= curPrio;
        ccReg_r <= ccWithPrio(ccReg_r, winPrio);
        if (edgeMode_r[winIdx])
          latch_r[winIdx] <= rawReq[winIdx];
      end
      // Nesting depth is the CPU's stack; nothing here watches for overflow.
    end
  end
endmodule // npic_nested_irq

/* verification/npic_src_model.sv */
`timescale 1ns/1ps
module npic_src_model #(
  parameter NSRC = 14,
  parameter NEXT = 4,
  parameter PINS = 4
)
(
  // Clock and reset.
  input wire clk_sys,
  input wire reset_n,
  // Event commands from the bench.
  input wire [NSRC-1:0] evtSet,
  input wire [NSRC-1:0] evtClr,
  // Requests toward the controller.
  output reg [NEXT*PINS-1:0] extPins,
  output reg [NSRC-1:0] periphFlag
);
  reg [NSRC-1:0] evt_r;
  integer i;
  // An event flag stays set until its source runs the clearing sequence.
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      evt_r <= {NSRC{1'b0}};
    else
      evt_r <= (evt_r & ~evtClr) | evtSet;
  end
  // External lines use their second pin, so only the pin OR can carry them.
  always @*
  begin
    extPins = {NEXT*PINS{1'b0}};
    periphFlag = evt_r;
    for (i = 0; i < NEXT; i = i + 1)
    begin
      extPins[i*PINS+1] = evt_r[i];
      periphFlag[i] = 1'b0;
    end
  end
endmodule // npic_src_model

/* verification/npic_nested_irq_assertions.sv */
`timescale 1ns/1ps
module npic_chk (
  // Clock and reset.
  input wire clk_sys,
  input wire reset_n,
  // Bus.
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // CPU side.
  input wire entryStart,
  input wire entryStack,
  input wire [15:0] vectorAddr,
  input wire cpuAwake
);
  reg [1:0] bootCnt_r;
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      bootCnt_r <= 2'h0;
    else if (bootCnt_r != 2'h2)
      bootCnt_r <= bootCnt_r + 2'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  chk_boot_vector: assert property (
    bootCnt_r == 2'h1 |-> entryStart && !entryStack && vectorAddr == 16'hFFFE)
    else $error("reset vector not taken first");
  chk_reset_nostack: assert property (
    entryStart && vectorAddr == 16'hFFFE |-> !entryStack) else $error("reset stacked");
  chk_entry_stacks: assert property (
    entryStart && vectorAddr != 16'hFFFE |-> entryStack) else $error("entry not stacked");
  chk_stack_start: assert property (
    entryStack |-> entryStart) else $error("stack without entry");
  chk_vector_top: assert property (
    entryStart |-> vectorAddr >= 16'hFFE0 && !vectorAddr[0]) else $error("vector off table");
  chk_vector_held: assert property (
    $changed(vectorAddr) |-> entryStart) else $error("vector moved without entry");
  chk_entry_pulse: assert property (
    entryStart |=> !entryStart) else $error("entry pulse too long");
  chk_ready_setup: assert property (
    psel && !penable |=> pready) else $error("no ready after setup");
  chk_ready_single: assert property (
    pready |=> !pready) else $error("ready held");
  chk_err_ready: assert property (
    pslverr |-> pready) else $error("error without ready");
  cover property (entryStart && entryStack);
  cover property (pslverr);
  cover property ($fell(cpuAwake));
endmodule // npic_chk
bind npic_nested_irq npic_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .entryStart(entryStart),
  .entryStack(entryStack), .vectorAddr(vectorAddr), .cpuAwake(cpuAwake));

/* verification/tb.sv */
`timescale 1ns/1ps
`include "npic_defs.vh"
module tb;
  reg clk_sys = 1'b0;
  reg reset_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [15:0] extPinSel = 16'hFFFF;
  reg [13:0] evtSet = 14'h0;
  reg [13:0] evtClr = 14'h0;
  wire [31:0] prdata;
  wire pready, pslverr, entryStart, entryStack, cpuAwake;
  wire [15:0] vectorAddr, extPins;
  wire [13:0] periphFlag;
  integer error_cnt = 0, num_checks = 0, cycles = 0, entCnt = 0, c0;
  reg [31:0] rdData;
  reg [31:0] rdErr;
  reg [15:0] entVec;
  reg entStk;
  always #12.5 clk_sys = ~clk_sys;
  npic_nested_irq dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extPins(extPins), .extPinSel(extPinSel), .periphFlag(periphFlag),
    .entryStart(entryStart), .entryStack(entryStack), .vectorAddr(vectorAddr),
    .cpuAwake(cpuAwake));
  npic_src_model src (.clk_sys(clk_sys), .reset_n(reset_n), .evtSet(evtSet),
    .evtClr(evtClr), .extPins(extPins), .periphFlag(periphFlag));
  task report_and_stop;
    begin
      if (error_cnt == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge clk_sys)
  begin
    cycles = cycles + 1;
    if (entryStart === 1'b1)
    begin
      entCnt = entCnt + 1;
      entVec = vectorAddr;
      entStk = entryStack;
    end
    if (cycles == 20000)
    begin
      error_cnt = error_cnt + 1;
      report_and_stop;
    end
  end
  task chk(input string name, input [31:0] exp, input [31:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        $display("[ERR] %0s expected %h seen %h", name, exp, got);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  task xfer(input wr, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk_sys);
        n = n + 1;
      end
      while (pready !== 1'b1 && n < 50);
      rdData = prdata;
      rdErr = {31'h0, pslverr};
      chk("pready", 32'h1, {31'h0, pready});
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task cc_lvl(input [1:0] lvl);
    begin
      xfer(1'b0, `NPIC_ADDR_CC, 32'h0);
      chk("ccLevel", {30'h0, lvl}, {30'h0, rdData[`NPIC_CC_HI], rdData[`NPIC_CC_LO]});
    end
  endtask
  task events(input [13:0] s, input [13:0] c);
    begin
      @(posedge clk_sys);
      evtSet <= s;
      evtClr <= c;
      @(posedge clk_sys);
      evtSet <= 14'h0;
      evtClr <= 14'h0;
      repeat (8) @(posedge clk_sys);
    end
  endtask
  // Entry begins one cycle after the command write, so twenty cycles is generous.
  task entry(input [15:0] vec, input [31:0] cmd);
    integer n;
    begin
      c0 = entCnt;
      xfer(1'b1, `NPIC_ADDR_CMD, cmd);
      for (n = 0; n < 20 && entCnt == c0; n = n + 1)
        @(posedge clk_sys);
      chk("entryCount", c0 + 1, entCnt);
      chk("vector", {16'h0, vec}, {16'h0, entVec});
      chk("stacked", 32'h1, {31'h0, entStk});
    end
  endtask
  task test_regs;
    begin
      xfer(1'b0, `NPIC_ADDR_CC, 32'h0);
      chk("ccReset", 32'hEA, rdData);
      xfer(1'b0, `NPIC_ADDR_PRIO0, 32'h0);
      chk("prioReset", 32'hFF, rdData);
      xfer(1'b1, `NPIC_ADDR_PRIO0, 32'h64);
      xfer(1'b0, `NPIC_ADDR_PRIO0, 32'h0);
      chk("prioKeep", 32'h74, rdData);
      xfer(1'b0, 12'h0FC, 32'h0);
      chk("unmapped", 32'h1, rdErr);
      xfer(1'b1, `NPIC_ADDR_CMD, 32'h1);
      cc_lvl(`NPIC_LVL0);
      xfer(1'b1, `NPIC_ADDR_CMD, 32'h2);
      cc_lvl(`NPIC_LVL3);
    end
  endtask
  task test_nesting;
    begin
      xfer(1'b1, `NPIC_ADDR_PRIO0, 32'hF1);
      xfer(1'b1, `NPIC_ADDR_ENA, 32'h3);
      xfer(1'b1, `NPIC_ADDR_EDGE, 32'h0);
      xfer(1'b1, `NPIC_ADDR_CMD, 32'h1);
      events(14'h3, 14'h0);
      entry(16'hFFF8, 32'h40);
      cc_lvl(`NPIC_LVL2);
      events(14'h0, 14'h2);
      xfer(1'b1, `NPIC_ADDR_CLR, 32'h2);
      c0 = entCnt;
      xfer(1'b1, `NPIC_ADDR_CMD, 32'h40);
      repeat (6) @(posedge clk_sys);
      chk("noEntry", c0, entCnt);
      xfer(1'b1, `NPIC_ADDR_CMD, 32'h20);
      cc_lvl(`NPIC_LVL0);
      entry(16'hFFFA, 32'h40);
      cc_lvl(`NPIC_LVL1);
      events(14'h0, 14'h1);
      xfer(1'b1, `NPIC_ADDR_CLR, 32'h1);
    end
  endtask
  task test_trap_halt;
    integer n;
    begin
      // A deselected pin must not reach its line; reselecting it must.
      extPinSel <= 16'hFFFD;
      events(14'h1, 14'h0);
      xfer(1'b0, `NPIC_ADDR_STAT, 32'h0);
      chk("pinMasked", 32'h0, rdData);
      extPinSel <= 16'hFFFF;
      repeat (4) @(posedge clk_sys);
      xfer(1'b0, `NPIC_ADDR_STAT, 32'h0);
      chk("pinOred", 32'h1, rdData);
      events(14'h0, 14'h1);
      xfer(1'b1, `NPIC_ADDR_CLR, 32'h1);
      entry(`NPIC_VEC_TRAP, 32'h50);
      cc_lvl(`NPIC_LVL3);
      // Source four outranks source zero but cannot leave halt.
      xfer(1'b1, `NPIC_ADDR_PRIO1, 32'hFC);
      xfer(1'b1, `NPIC_ADDR_ENA, 32'h15);
      xfer(1'b1, `NPIC_ADDR_EDGE, 32'h4);
      events(14'h10, 14'h0);
      xfer(1'b1, `NPIC_ADDR_CMD, 32'h4);
      repeat (4) @(posedge clk_sys);
      chk("asleep", 32'h0, {31'h0, cpuAwake});
      events(14'h1, 14'h0);
      for (n = 0; n < 20 && cpuAwake !== 1'b1; n = n + 1)
        @(posedge clk_sys);
      chk("awake", 32'h1, {31'h0, cpuAwake});
      entry(16'hFFFA, 32'h40);
      cc_lvl(`NPIC_LVL1);
      entry(16'hFFF2, 32'h40);
      cc_lvl(`NPIC_LVL2);
      events(14'h4, 14'h0);
      entry(16'hFFF6, 32'h40);
      xfer(1'b0, `NPIC_ADDR_STAT, 32'h0);
      chk("edgeCleared", 32'h11, rdData);
      events(14'h0, 14'h10);
      xfer(1'b1, `NPIC_ADDR_CLR, 32'h10);
      xfer(1'b0, `NPIC_ADDR_STAT, 32'h0);
      chk("latchDropped", 32'h1, rdData);
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    test_regs;
    test_nesting;
    test_trap_halt;
    report_and_stop;
  end
endmodule // tb
